// ==== common/dfc_cfg_if.sv ====
/*
 * Carries the six stored configuration bytes from the register bank to
 * the field decoder. Assumes both ends share clk_sys.
 */
`timescale 1ns/1ps
interface dfc_cfg_if;
	logic [7:0] det;
	logic [7:0] lim;
	logic [7:0] gain;
	logic [7:0] cap;
	logic [7:0] mix;
	logic [7:0] prot;
	modport regs(output det, lim, gain, cap, mix, prot);
	modport dec(input det, lim, gain, cap, mix, prot);
endinterface

// ==== common/dfc_pkg.sv ====
/*
 * Constants for the feature configuration register bank: offsets, reset
 * values, write masks, field positions and decoded figures.
 * Assumes byte-wide registers on a byte-addressed host control port.
 */
package dfc_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] DET_ADDR = 8'h20;
	localparam logic [7:0] LIM_ADDR = 8'h23;
	localparam logic [7:0] GAIN_ADDR = 8'h24;
	localparam logic [7:0] CAP_ADDR = 8'h2b;
	localparam logic [7:0] MIX_ADDR = 8'h2c;
	localparam logic [7:0] PROT_ADDR = 8'h2d;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] DET_RST = 8'h00;
	localparam logic [7:0] LIM_RST = 8'h00;
	localparam logic [7:0] GAIN_RST = 8'h00;
	localparam logic [7:0] CAP_RST = 8'h00;
	localparam logic [7:0] MIX_RST = 8'h00;
	localparam logic [7:0] PROT_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ****************************************
	// Writable bits
	// ****************************************
	localparam logic [7:0] DET_WMASK = 8'hfc;
	localparam logic [7:0] LIM_WMASK = 8'hf0;
	localparam logic [7:0] GAIN_WMASK = 8'hff;
	localparam logic [7:0] CAP_WMASK = 8'hfc;
	localparam logic [7:0] MIX_WMASK = 8'hf0;
	localparam logic [7:0] PROT_WMASK = 8'hff;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int DET_CLK_LSB = 6;
	localparam int DET_RATE_LSB = 4;
	localparam int DET_PH1_BIT = 2;
	localparam int LIM_SRC_LSB = 6;
	localparam int LIM_TGT_LSB = 4;
	localparam int GAIN_AGC_MSB = 7;
	localparam int GAIN_DRC_MSB = 3;
	localparam int CAP_EN_BIT = 7;
	localparam int CAP_ATTN_LSB = 4;
	localparam int CAP_SRC_BIT = 3;
	localparam int CAP_REL_BIT = 2;
	localparam int MIX_PORT_BIT = 7;
	localparam int MIX_SIDE_BIT = 6;
	localparam int MIX_REC_BIT = 5;
	localparam int MIX_LOOP_BIT = 4;
	localparam int PROT_DIST_BIT = 7;
	localparam int PROT_BOP_BIT = 6;
	localparam int PROT_THERM_BIT = 5;
	localparam int PROT_DRC_BIT = 4;
	localparam int PROT_GEN1_BIT = 3;
	localparam int PROT_GEN2_BIT = 2;
	localparam int PROT_MON_BIT = 1;
	localparam int PROT_BRWN_BIT = 0;

	// ****************************************
	// Decoded figures
	// ****************************************
	// External clock rates in kHz: 24.576, 6.144, 12.288, 18.432 MHz
	localparam logic [14:0] RATE0_KHZ = 15'h6000;
	localparam logic [14:0] RATE1_KHZ = 15'h1800;
	localparam logic [14:0] RATE2_KHZ = 15'h3000;
	localparam logic [14:0] RATE3_KHZ = 15'h4800;
	localparam logic [5:0] ATTN_STEP_DB = 6'h06;

	// Two-bit code to one-hot
	function automatic logic [3:0] dfc_onehot4(input logic [1:0] sel);
		dfc_onehot4 = 4'h1 << sel;
	endfunction

endpackage

// ==== rtl/dfc_decode.sv ====
/*
 * Registered decode of the stored configuration into one-hot selects,
 * clock rate, attenuation in dB and gated enables.
 * Assumes the bank drives the interface from flip-flops on clk_sys.
 */
`timescale 1ns/1ps
module dfc_decode (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Stored configuration
	dfc_cfg_if.dec cfg,
	// Decoded outputs
	output logic [3:0] det_clk_onehot,
	output logic [14:0] det_ext_rate_khz,
	output logic [3:0] lim_src_onehot,
	output logic lim_apply_a,
	output logic lim_apply_b,
	output logic [5:0] cap_attn_db,
	output logic cap_may_release,
	output logic [3:0] range_comp_active
);

	typedef struct packed {
		logic [3:0] clk_oh;
		logic [14:0] rate;
		logic [3:0] src_oh;
		logic app_a;
		logic app_b;
		logic [5:0] attn;
		logic rel;
		logic [3:0] comp;
	} dfc_dec_t;

	dfc_dec_t dec_r;
	dfc_dec_t dec_nxt;
	logic [1:0] tgt;

	// ****************************************
	// Decode
	// ****************************************
	assign tgt = cfg.lim[dfc_pkg::LIM_TGT_LSB +: 2];

	always_comb begin
		dec_nxt = dec_r;
		dec_nxt.clk_oh = dfc_pkg::dfc_onehot4(cfg.det[dfc_pkg::DET_CLK_LSB +: 2]);
		case (cfg.det[dfc_pkg::DET_RATE_LSB +: 2])
			2'h0: dec_nxt.rate = dfc_pkg::RATE0_KHZ;
			2'h1: dec_nxt.rate = dfc_pkg::RATE1_KHZ;
			2'h2: dec_nxt.rate = dfc_pkg::RATE2_KHZ;
			default: dec_nxt.rate = dfc_pkg::RATE3_KHZ;
		endcase
		dec_nxt.src_oh = dfc_pkg::dfc_onehot4(cfg.lim[dfc_pkg::LIM_SRC_LSB +: 2]);
		dec_nxt.app_a = (tgt == 2'h0) || (tgt == 2'h2);
		dec_nxt.app_b = (tgt == 2'h0) || (tgt == 2'h1);
		dec_nxt.attn = 6'(6'(cfg.cap[dfc_pkg::CAP_ATTN_LSB +: 3]) * dfc_pkg::ATTN_STEP_DB);
		dec_nxt.rel = cfg.cap[dfc_pkg::CAP_EN_BIT] & cfg.cap[dfc_pkg::CAP_REL_BIT];
		for (int i = 0; i < 4; i++) begin
			dec_nxt.comp[i] = cfg.prot[dfc_pkg::PROT_DRC_BIT] & cfg.gain[dfc_pkg::GAIN_DRC_MSB - i];
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			dec_r <= '{clk_oh: 4'h1, rate: dfc_pkg::RATE0_KHZ, src_oh: 4'h1, app_a: 1'b1,
				app_b: 1'b1, attn: 6'h00, rel: 1'b0, comp: 4'h0};
		end else begin
			dec_r <= dec_nxt;
		end
	end

	assign det_clk_onehot = dec_r.clk_oh;
	assign det_ext_rate_khz = dec_r.rate;
	assign lim_src_onehot = dec_r.src_oh;
	assign lim_apply_a = dec_r.app_a;
	assign lim_apply_b = dec_r.app_b;
	assign cap_attn_db = dec_r.attn;
	assign cap_may_release = dec_r.rel;
	assign range_comp_active = dec_r.comp;

	// ****************************************
	// Checks
	// ****************************************
	attn_db_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		##1 cap_attn_db == 6'($past(cfg.cap[6:4]) * 6'h06))
		else $error("Attenuation in dB does not match code");
	comp_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!cfg.prot[4] |=> range_comp_active == 4'h0)
		else $error("Compression active with global enable clear");

endmodule

// ==== rtl/dfc_regs.sv ====
/*
 * Byte-wide feature configuration register bank on the host control port,
 * with raw field outputs and a registered field decoder.
 * Assumes host port signals are synchronous to clk_sys.
 */
`timescale 1ns/1ps
module dfc_regs #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Host control port
	input wire logic [ADDR_W-1:0] host_addr,
	input wire logic host_wr_en,
	input wire logic [7:0] host_wr_data,
	input wire logic host_rd_en,
	output logic [7:0] host_rd_data,
	output logic host_rd_valid,
	// Activity detector clocking
	output logic [1:0] detector_clock_select,
	output logic [1:0] detector_ext_clock_rate,
	output logic detector_phase_one_enable,
	// Limiter routing
	output logic [1:0] limiter_source_select,
	output logic [1:0] limiter_target_select,
	// Per-channel enables, index 0 is channel 1
	output logic [3:0] auto_gain_chan_enable,
	output logic [3:0] range_comp_chan_enable,
	// Battery power cap
	output logic power_cap_enable,
	output logic [2:0] power_cap_attenuation,
	output logic power_cap_source,
	output logic power_cap_release,
	// Mixers
	output logic playback_port_mix_enable,
	output logic side_chain_mix_enable,
	output logic record_chan_mix_enable,
	output logic loopback_mix_enable,
	// Protection and generators
	output logic distortion_limit_enable,
	output logic brownout_protect_enable,
	output logic thermal_foldback_enable,
	output logic range_comp_enable,
	output logic [1:0] tone_gen_enable,
	output logic monitor_source_select,
	output logic brownout_shutdown_enable,
	// Decoded views
	output logic [3:0] det_clk_onehot,
	output logic [14:0] det_ext_rate_khz,
	output logic [3:0] lim_src_onehot,
	output logic lim_apply_a,
	output logic lim_apply_b,
	output logic [5:0] cap_attn_db,
	output logic cap_may_release,
	output logic [3:0] range_comp_active
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] det;
		logic [7:0] lim;
		logic [7:0] gain;
		logic [7:0] cap;
		logic [7:0] mix;
		logic [7:0] prot;
		logic [7:0] rd_data;
		logic rd_valid;
	} dfc_state_t;

	localparam dfc_state_t STATE_RST = '{
		det: dfc_pkg::DET_RST,
		lim: dfc_pkg::LIM_RST,
		gain: dfc_pkg::GAIN_RST,
		cap: dfc_pkg::CAP_RST,
		mix: dfc_pkg::MIX_RST,
		prot: dfc_pkg::PROT_RST,
		rd_data: dfc_pkg::UNMAPPED_READ,
		rd_valid: 1'b0
	};

	dfc_state_t state_r;
	dfc_state_t state_nxt;
	logic [7:0] addr8;

	// ****************************************
	// Parameter check
	// ****************************************
	generate
		if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr
			$error("ADDR_W must lie between 6 and 8");
		end
	endgenerate

	assign addr8 = 8'(host_addr);

	// ****************************************
	// Read decode
	// ****************************************
	function automatic logic [7:0] read_byte(input dfc_state_t s, input logic [7:0] a);
		case (a)
			dfc_pkg::DET_ADDR: read_byte = s.det;
			dfc_pkg::LIM_ADDR: read_byte = s.lim;
			dfc_pkg::GAIN_ADDR: read_byte = s.gain;
			dfc_pkg::CAP_ADDR: read_byte = s.cap;
			dfc_pkg::MIX_ADDR: read_byte = s.mix;
			dfc_pkg::PROT_ADDR: read_byte = s.prot;
			default: read_byte = dfc_pkg::UNMAPPED_READ;
		endcase
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		state_nxt.rd_valid = host_rd_en;
		if (host_rd_en) begin
			state_nxt.rd_data = read_byte(state_r, addr8);
		end
		if (host_wr_en) begin
			case (addr8)
				dfc_pkg::DET_ADDR: begin
					state_nxt.det = host_wr_data & dfc_pkg::DET_WMASK;
				end
				dfc_pkg::LIM_ADDR: begin
					state_nxt.lim = host_wr_data & dfc_pkg::LIM_WMASK;
				end
				dfc_pkg::GAIN_ADDR: begin
					state_nxt.gain = host_wr_data & dfc_pkg::GAIN_WMASK;
				end
				dfc_pkg::CAP_ADDR: begin
					state_nxt.cap = host_wr_data & dfc_pkg::CAP_WMASK;
				end
				dfc_pkg::MIX_ADDR: begin
					state_nxt.mix = host_wr_data & dfc_pkg::MIX_WMASK;
				end
				dfc_pkg::PROT_ADDR: begin
					state_nxt.prot = host_wr_data & dfc_pkg::PROT_WMASK;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= STATE_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign host_rd_data = state_r.rd_data;
	assign host_rd_valid = state_r.rd_valid;

	// ****************************************
	// Raw field outputs
	// ****************************************
	assign detector_clock_select = state_r.det[dfc_pkg::DET_CLK_LSB +: 2];
	assign detector_ext_clock_rate = state_r.det[dfc_pkg::DET_RATE_LSB +: 2];
	assign detector_phase_one_enable = state_r.det[dfc_pkg::DET_PH1_BIT];
	assign limiter_source_select = state_r.lim[dfc_pkg::LIM_SRC_LSB +: 2];
	assign limiter_target_select = state_r.lim[dfc_pkg::LIM_TGT_LSB +: 2];

	// Channel 1 sits in the highest bit of each nibble
	generate
		for (genvar i = 0; i < 4; i++) begin : g_chan
			assign auto_gain_chan_enable[i] = state_r.gain[dfc_pkg::GAIN_AGC_MSB - i];
			assign range_comp_chan_enable[i] = state_r.gain[dfc_pkg::GAIN_DRC_MSB - i];
		end
	endgenerate

	assign power_cap_enable = state_r.cap[dfc_pkg::CAP_EN_BIT];
	assign power_cap_attenuation = state_r.cap[dfc_pkg::CAP_ATTN_LSB +: 3];
	assign power_cap_source = state_r.cap[dfc_pkg::CAP_SRC_BIT];
	assign power_cap_release = state_r.cap[dfc_pkg::CAP_REL_BIT];
	assign playback_port_mix_enable = state_r.mix[dfc_pkg::MIX_PORT_BIT];
	assign side_chain_mix_enable = state_r.mix[dfc_pkg::MIX_SIDE_BIT];
	assign record_chan_mix_enable = state_r.mix[dfc_pkg::MIX_REC_BIT];
	assign loopback_mix_enable = state_r.mix[dfc_pkg::MIX_LOOP_BIT];
	assign distortion_limit_enable = state_r.prot[dfc_pkg::PROT_DIST_BIT];
	assign brownout_protect_enable = state_r.prot[dfc_pkg::PROT_BOP_BIT];
	assign thermal_foldback_enable = state_r.prot[dfc_pkg::PROT_THERM_BIT];
	assign range_comp_enable = state_r.prot[dfc_pkg::PROT_DRC_BIT];
	assign tone_gen_enable[0] = state_r.prot[dfc_pkg::PROT_GEN1_BIT];
	assign tone_gen_enable[1] = state_r.prot[dfc_pkg::PROT_GEN2_BIT];
	assign monitor_source_select = state_r.prot[dfc_pkg::PROT_MON_BIT];
	assign brownout_shutdown_enable = state_r.prot[dfc_pkg::PROT_BRWN_BIT];

	// ****************************************
	// Field decoder
	// ****************************************
	dfc_cfg_if cfg_bus();

	assign cfg_bus.det = state_r.det;
	assign cfg_bus.lim = state_r.lim;
	assign cfg_bus.gain = state_r.gain;
	assign cfg_bus.cap = state_r.cap;
	assign cfg_bus.mix = state_r.mix;
	assign cfg_bus.prot = state_r.prot;

	dfc_decode u_decode (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.cfg(cfg_bus.dec),
		.det_clk_onehot(det_clk_onehot),
		.det_ext_rate_khz(det_ext_rate_khz),
		.lim_src_onehot(lim_src_onehot),
		.lim_apply_a(lim_apply_a),
		.lim_apply_b(lim_apply_b),
		.cap_attn_db(cap_attn_db),
		.cap_may_release(cap_may_release),
		.range_comp_active(range_comp_active)
	);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	reset_vals_a: assert property (disable iff (1'b0)
		!reset_n ##1 !reset_n |-> (state_r.det == 8'h00 && state_r.lim == 8'h00
		&& state_r.gain == 8'h00 && state_r.cap == 8'h00 && state_r.mix == 8'h00
		&& state_r.prot == 8'h00))
		else $error("Configuration not zero under reset");

	det_write_a: assert property (
		host_wr_en && addr8 == 8'h20 |=> detector_clock_select == $past(host_wr_data[7:6])
		&& detector_ext_clock_rate == $past(host_wr_data[5:4])
		&& detector_phase_one_enable == $past(host_wr_data[2]))
		else $error("Detector fields not taken from write");

	clk_decode_a: assert property (
		host_wr_en && addr8 == 8'h20 && host_wr_data[7:6] == 2'h2 |=> ##1 det_clk_onehot == 4'h4)
		else $error("Aux clock select not decoded");

	rate_decode_a: assert property (
		host_wr_en && addr8 == 8'h20 && host_wr_data[5:4] == 2'h1 |=> ##1 det_ext_rate_khz == 15'h1800)
		else $error("External clock rate wrong");

	lim_route_a: assert property (
		host_wr_en && addr8 == 8'h23 && host_wr_data[5:4] == 2'h3 |=> ##1 !lim_apply_a && !lim_apply_b)
		else $error("Limiter applied with target none");

	chan_order_a: assert property (
		host_wr_en && addr8 == 8'h24 |=> auto_gain_chan_enable == {$past(host_wr_data[4]),
		$past(host_wr_data[5]), $past(host_wr_data[6]), $past(host_wr_data[7])}
		&& range_comp_chan_enable == {$past(host_wr_data[0]), $past(host_wr_data[1]),
		$past(host_wr_data[2]), $past(host_wr_data[3])})
		else $error("Channel enable order wrong");

	cap_write_a: assert property (
		host_wr_en && addr8 == 8'h2b |=> power_cap_enable == $past(host_wr_data[7])
		&& power_cap_attenuation == $past(host_wr_data[6:4])
		&& power_cap_source == $past(host_wr_data[3]) && power_cap_release == $past(host_wr_data[2]))
		else $error("Power cap fields not taken from write");

	prot_write_a: assert property (
		host_wr_en && addr8 == 8'h2d |=> {distortion_limit_enable, brownout_protect_enable,
		thermal_foldback_enable, range_comp_enable, tone_gen_enable[0], tone_gen_enable[1],
		monitor_source_select, brownout_shutdown_enable} == $past(host_wr_data))
		else $error("Protection enables not taken from write");

	mix_write_a: assert property (
		host_wr_en && addr8 == 8'h2c |=> {playback_port_mix_enable, side_chain_mix_enable,
		record_chan_mix_enable, loopback_mix_enable} == $past(host_wr_data[7:4]))
		else $error("Mixer enables not taken from write");

	ro_bits_a: assert property (
		host_wr_en && addr8 == 8'h23 ##1 host_rd_en && addr8 == 8'h23 && !host_wr_en
		|=> host_rd_valid && host_rd_data == ($past(host_wr_data, 2) & 8'hf0))
		else $error("Read back differs from masked write");

	unmapped_a: assert property (
		host_wr_en && addr8 == 8'h21 |=> $stable(state_r.det) && $stable(state_r.lim)
		&& $stable(state_r.gain) && $stable(state_r.cap) && $stable(state_r.mix)
		&& $stable(state_r.prot))
		else $error("Unmapped write changed a register");

	unmapped_read_a: assert property (
		host_rd_en && addr8 == 8'h30 |=> host_rd_valid && host_rd_data == 8'h00)
		else $error("Unmapped read not zero");

	rd_pulse_a: assert property (
		host_rd_valid == $past(host_rd_en))
		else $error("Read valid is not one cycle after the read strobe");

	rd_hold_a: assert property (
		!host_rd_en |=> $stable(host_rd_data))
		else $error("Read data changed without a read");

	no_write_a: assert property (
		!host_wr_en |=> $stable({state_r.det, state_r.lim, state_r.gain, state_r.cap,
		state_r.mix, state_r.prot}))
		else $error("Register changed without a write");

	ro_zero_a: assert property (
		state_r.det[1:0] == 2'h0 && state_r.lim[3:0] == 4'h0 && state_r.cap[1:0] == 2'h0
		&& state_r.mix[3:0] == 4'h0)
		else $error("Read-only reserved bit stored");

	may_release_a: assert property (
		cap_may_release == $past(power_cap_enable && power_cap_release))
		else $error("Release permission not gated by enable");

	src_decode_a: assert property (
		lim_src_onehot == 4'(4'h1 << $past(limiter_source_select)))
		else $error("Limiter source not one-hot decoded");

	apply_decode_a: assert property (
		lim_apply_a == ($past(limiter_target_select) == 2'h0
		|| $past(limiter_target_select) == 2'h2)
		&& lim_apply_b == ($past(limiter_target_select) == 2'h0
		|| $past(limiter_target_select) == 2'h1))
		else $error("Limiter target not decoded");

	full_attn_c: cover property (host_wr_en && addr8 == 8'h2b && host_wr_data == 8'hfc ##2
		cap_attn_db == 6'h2a);
	prot_read_c: cover property (host_wr_en && addr8 == 8'h2d ##1 host_rd_en && addr8 == 8'h2d);
	comp_on_c: cover property (range_comp_active == 4'hf);
	custom_clk_c: cover property (det_clk_onehot == 4'h8);

endmodule

// ==== tb/tb_dfc_regs.sv ====
/*
 * Self-checking bench for the feature configuration register bank.
 * Assumes the bank at its default address width, driven on clk_sys.
 */
`timescale 1ns/1ps
module tb_dfc_regs;

	// ****************************************
	// Signals and instance
	// ****************************************
	logic clk_sys, reset_n, host_wr_en, host_rd_en, host_rd_valid;
	logic [7:0] host_addr, host_wr_data, host_rd_data;
	logic [1:0] detector_clock_select, detector_ext_clock_rate, limiter_source_select;
	logic [1:0] limiter_target_select, tone_gen_enable;
	logic [3:0] auto_gain_chan_enable, range_comp_chan_enable, det_clk_onehot;
	logic [3:0] lim_src_onehot, range_comp_active;
	logic [2:0] power_cap_attenuation;
	logic [14:0] det_ext_rate_khz;
	logic [5:0] cap_attn_db;
	logic detector_phase_one_enable, power_cap_enable, power_cap_source, power_cap_release;
	logic playback_port_mix_enable, side_chain_mix_enable, record_chan_mix_enable;
	logic loopback_mix_enable, distortion_limit_enable, brownout_protect_enable;
	logic thermal_foldback_enable, range_comp_enable, monitor_source_select;
	logic brownout_shutdown_enable, lim_apply_a, lim_apply_b, cap_may_release;
	int mismatches, cmp_count;
	logic [7:0] addrs [6] = '{8'h20, 8'h23, 8'h24, 8'h2b, 8'h2c, 8'h2d};
	logic [7:0] masks [6] = '{8'hfc, 8'hf0, 8'hff, 8'hfc, 8'hf0, 8'hff};
	logic [14:0] rates [4] = '{15'h6000, 15'h1800, 15'h3000, 15'h4800};

	dfc_regs u_dfc_regs (.clk_sys, .reset_n, .host_addr, .host_wr_en, .host_wr_data,
		.host_rd_en, .host_rd_data, .host_rd_valid, .detector_clock_select,
		.detector_ext_clock_rate, .detector_phase_one_enable, .limiter_source_select,
		.limiter_target_select, .auto_gain_chan_enable, .range_comp_chan_enable,
		.power_cap_enable, .power_cap_attenuation, .power_cap_source, .power_cap_release,
		.playback_port_mix_enable, .side_chain_mix_enable, .record_chan_mix_enable,
		.loopback_mix_enable, .distortion_limit_enable, .brownout_protect_enable,
		.thermal_foldback_enable, .range_comp_enable, .tone_gen_enable,
		.monitor_source_select, .brownout_shutdown_enable, .det_clk_onehot,
		.det_ext_rate_khz, .lim_src_onehot, .lim_apply_a, .lim_apply_b, .cap_attn_db,
		.cap_may_release, .range_comp_active);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic wrap_up;
		$display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic step;
		@(posedge clk_sys);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		step();
		host_wr_en = 1'b1;
		host_addr = a;
		host_wr_data = d;
		step();
		host_wr_en = 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		int n;
		step();
		host_rd_en = 1'b1;
		host_addr = a;
		step();
		host_rd_en = 1'b0;
		n = 0;
		while (host_rd_valid !== 1'b1 && n < 4) begin
			step();
			n++;
		end
		if (host_rd_valid !== 1'b1) begin
			mismatches++;
			wrap_up();
		end else begin
			chk("rd_data", {8'h00, host_rd_data}, {8'h00, exp});
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		for (int i = 0; i < 6; i++) rdchk(addrs[i], 8'h00);
		step();
		chk("rd_valid", {15'h0, host_rd_valid}, 16'h0);
		chk("det_onehot", {12'h0, det_clk_onehot}, 16'h1);
		chk("ext_rate", {1'b0, det_ext_rate_khz}, 16'h6000);
		chk("lim_apply", {14'h0, lim_apply_a, lim_apply_b}, 16'h3);
		chk("gain_en", {8'h0, auto_gain_chan_enable, range_comp_chan_enable}, 16'h0);
	endtask

	task automatic t_masks;
		for (int i = 0; i < 6; i++) begin
			wr(addrs[i], 8'hff);
			rdchk(addrs[i], masks[i]);
		end
		wr(8'h21, 8'hff);
		rdchk(8'h21, 8'h00);
		rdchk(8'h30, 8'h00);
		for (int i = 0; i < 6; i++) wr(addrs[i], 8'h00);
		rdchk(8'h2d, 8'h00);
	endtask

	task automatic t_codes;
		logic [1:0] c;
		for (int i = 0; i < 4; i++) begin
			c = i[1:0];
			wr(8'h20, {c, ~c, 4'h4});
			chk("clk_sel", {14'h0, detector_clock_select}, {14'h0, c});
			chk("ext_rate", {14'h0, detector_ext_clock_rate}, {14'h0, ~c});
			chk("ph1", {15'h0, detector_phase_one_enable}, 16'h1);
			wr(8'h23, {c, c, 4'h0});
			chk("lim_src", {14'h0, limiter_source_select}, {14'h0, c});
			chk("lim_tgt", {14'h0, limiter_target_select}, {14'h0, c});
			step();
			chk("clk_onehot", {12'h0, det_clk_onehot}, 16'h1 << c);
			chk("rate_khz", {1'b0, det_ext_rate_khz}, {1'b0, rates[3 - i]});
			chk("src_onehot", {12'h0, lim_src_onehot}, 16'h1 << c);
			chk("apply", {14'h0, lim_apply_a, lim_apply_b},
				{14'h0, c == 2'd0 || c == 2'd2, c == 2'd0 || c == 2'd1});
		end
	endtask

	task automatic t_cap;
		logic [2:0] c;
		for (int i = 0; i < 8; i++) begin
			c = i[2:0];
			wr(8'h2b, {1'b1, c, c[0], ~c[0], 2'b11});
			chk("cap_en", {15'h0, power_cap_enable}, 16'h1);
			chk("cap_attn", {13'h0, power_cap_attenuation}, {13'h0, c});
			chk("cap_src", {15'h0, power_cap_source}, {15'h0, c[0]});
			chk("cap_rel", {15'h0, power_cap_release}, {15'h0, ~c[0]});
			step();
			chk("attn_db", {10'h0, cap_attn_db}, 16'(i * 6));
			chk("may_rel", {15'h0, cap_may_release}, {15'h0, ~c[0]});
		end
		wr(8'h2b, 8'h04);
		chk("cap_off", {15'h0, power_cap_enable}, 16'h0);
	endtask

	task automatic t_bits(input logic [7:0] p);
		wr(8'h24, p);
		wr(8'h2c, p);
		wr(8'h2d, p);
		chk("agc", {12'h0, auto_gain_chan_enable}, {12'h0, p[4], p[5], p[6], p[7]});
		chk("drc", {12'h0, range_comp_chan_enable}, {12'h0, p[0], p[1], p[2], p[3]});
		chk("mix", {12'h0, playback_port_mix_enable, side_chain_mix_enable,
			record_chan_mix_enable, loopback_mix_enable}, {12'h0, p[7:4]});
		chk("dist", {15'h0, distortion_limit_enable}, {15'h0, p[7]});
		chk("bop", {15'h0, brownout_protect_enable}, {15'h0, p[6]});
		chk("therm", {15'h0, thermal_foldback_enable}, {15'h0, p[5]});
		chk("drc_all", {15'h0, range_comp_enable}, {15'h0, p[4]});
		chk("tone", {14'h0, tone_gen_enable}, {14'h0, p[2], p[3]});
		chk("mon", {15'h0, monitor_source_select}, {15'h0, p[1]});
		chk("brwn", {15'h0, brownout_shutdown_enable}, {15'h0, p[0]});
		step();
		chk("drc_act", {12'h0, range_comp_active},
			{12'h0, {p[0], p[1], p[2], p[3]} & {4{p[4]}}});
	endtask

	task automatic t_same_cycle;
		wr(8'h24, 8'h11);
		step();
		host_wr_en = 1'b1;
		host_rd_en = 1'b1;
		host_wr_data = 8'h22;
		step();
		host_wr_en = 1'b0;
		host_rd_en = 1'b0;
		chk("old_rd", {8'h0, host_rd_data}, 16'h0011);
		rdchk(8'h24, 8'h22);
		// Write then read back in the very next cycle
		for (int i = 1; i < 6; i += 4) begin
			step();
			host_wr_en = 1'b1;
			host_addr = addrs[i];
			host_wr_data = 8'hff;
			step();
			host_wr_en = 1'b0;
			host_rd_en = 1'b1;
			step();
			host_rd_en = 1'b0;
			chk("wr_rd", {7'h0, host_rd_valid, host_rd_data}, {8'h01, masks[i]});
		end
	endtask

	task automatic t_mid_reset;
		wr(8'h2d, 8'hff);
		reset_n = 1'b0;
		#2;
		chk("rst_prot", {15'h0, distortion_limit_enable}, 16'h0);
		step();
		step();
		reset_n = 1'b1;
		rdchk(8'h2d, 8'h00);
	endtask

	// ****************************************
	// Clock and main sequence
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	initial begin
		reset_n = 1'b0;
		host_wr_en = 1'b0;
		host_rd_en = 1'b0;
		host_addr = 8'h00;
		host_wr_data = 8'h00;
		repeat (2) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		t_reset();
		t_masks();
		t_codes();
		t_cap();
		t_bits(8'ha5);
		t_bits(8'h5a);
		t_same_cycle();
		t_mid_reset();
		wrap_up();
	end

endmodule
